// *** core/rsfc_core.sv ***
// Top: fetch pipeline, program counter, shadow registers, register bus
//
// Chosen here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ns
module rsfc_core (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic POR_N,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic [20:0] PMEM_ADDR,
  input wire logic [15:0] PMEM_RDATA,
  output logic [20:0] TBL_ADDR,
  input wire logic [7:0] TBL_RDATA,
  input wire logic IRQ_HIGH,
  input wire logic IRQ_LOW,
  output logic [3:0] PHASE,
  output logic OPERAND_RD,
  output logic DEST_WR,
  output logic DEV_RESET
);
  rsfc_stack_if st ();
  logic core_rst;
  logic bus_rst;
  logic [20:0] pc;
  logic [15:0] fetch_buf;
  logic fetch_ok;
  logic [20:0] fetch_next;
  logic [15:0] instr;
  logic instr_ok;
  logic [20:0] exec_pc;
  logic [7:0] operand;
  logic [7:0] work;
  logic [7:0] status;
  logic [3:0] bank;
  logic [7:0] sh_status;
  logic [7:0] sh_work;
  logic [3:0] sh_bank;
  logic [7:0] hi_latch;
  logic [4:0] up_latch;
  logic [7:0] tdata;
  logic [1:0] ctrl;
  logic in_high;
  logic in_low;
  logic wr_go;
  rsfc_pkg::rsfc_op_t op;
  logic fast;
  logic irq_want;
  logic irq_take;
  logic exec;
  logic redirect;
  logic save_sh;
  logic load_sh;
  logic set_work;
  logic tbl_step;
  logic reti;
  logic [20:0] target;
  logic [7:0] work_val;
  logic [7:0] pcl_sum;

  assign bus_rst = !RST_N | !POR_N;
  assign core_rst = bus_rst | DEV_RESET;
  assign wr_go = AVS_WRITE & !AVS_WAITREQUEST;

  function automatic logic hit(input logic [7:0] ofs);
    hit = wr_go && (AVS_ADDRESS == ofs);
  endfunction : hit

  rsfc_phase u_phase (
    .clk(MCLK),
    .rst_n(!core_rst),
    .phase(PHASE)
  );

  rsfc_stack #(
    .DEPTH(rsfc_pkg::DEPTH)
  ) u_stack (
    .clk(MCLK),
    .rst_n(!core_rst),
    .por_n(POR_N),
    .st(st.stack)
  );

  ////////////////////////////////////////////////////////////////////////
  // Decode of the word in execution
  assign op = rsfc_pkg::rsfc_op_t'(instr[15:12]);
  assign fast = instr[rsfc_pkg::FAST_BIT];
  // A high request is accepted even inside low service
  assign irq_want = ctrl[rsfc_pkg::CTRL_IRQ_BIT]
    & ((IRQ_HIGH & !in_high) | (IRQ_LOW & !in_high & !in_low));
  assign irq_take = PHASE[3] & instr_ok & irq_want;
  assign exec = PHASE[3] & instr_ok & !irq_want;
  assign pcl_sum = exec_pc[7:0] + operand;

  assign st.sp_wr = hit(rsfc_pkg::OFS_SP);
  assign st.sp_wdata = AVS_WRITEDATA[4:0];
  assign st.clr_full = st.sp_wr & !AVS_WRITEDATA[rsfc_pkg::FULL_BIT];
  assign st.clr_unf = st.sp_wr & !AVS_WRITEDATA[rsfc_pkg::UNF_BIT];

  always_comb
  begin
    redirect = 1'b0;
    target = 21'h000000;
    st.push = 1'b0;
    st.pop = 1'b0;
    st.push_data = exec_pc;
    save_sh = 1'b0;
    load_sh = 1'b0;
    set_work = 1'b0;
    work_val = instr[7:0];
    tbl_step = 1'b0;
    reti = 1'b0;
    if (irq_take)
    begin
      // Vector in place of the held word, which is re-run on return
      redirect = 1'b1;
      target = (IRQ_HIGH & !in_high) ? rsfc_pkg::VEC_HIGH
        : rsfc_pkg::VEC_LOW;
      st.push = 1'b1;
      st.push_data = exec_pc - rsfc_pkg::PC_STEP;
      save_sh = 1'b1;
    end
    else if (exec)
    begin
      case (op)
        rsfc_pkg::OP_CALL:
        begin
          redirect = 1'b1;
          target = {9'h000, instr[10:0], 1'b0};
          st.push = 1'b1;
          save_sh = fast;
        end
        rsfc_pkg::OP_GOTO:
        begin
          redirect = 1'b1;
          target = {9'h000, instr[10:0], 1'b0};
        end
        rsfc_pkg::OP_BRA:
        begin
          redirect = 1'b1;
          // Offset counts words, so it is doubled into bytes
          target = exec_pc + {{9{instr[10]}}, instr[10:0], 1'b0};
        end
        rsfc_pkg::OP_RET:
        begin
          redirect = 1'b1;
          target = st.top;
          st.pop = 1'b1;
          load_sh = fast;
        end
        rsfc_pkg::OP_RETI:
        begin
          redirect = 1'b1;
          target = st.top;
          st.pop = 1'b1;
          load_sh = fast;
          reti = 1'b1;
        end
        rsfc_pkg::OP_RETLIT:
        begin
          redirect = 1'b1;
          target = st.top;
          st.pop = 1'b1;
          set_work = 1'b1;
        end
        rsfc_pkg::OP_ADDPC:
        begin
          redirect = 1'b1;
          // Latches fill the upper bits on a low byte write
          target = {up_latch, hi_latch, pcl_sum};
        end
        rsfc_pkg::OP_MOVLIT: set_work = 1'b1;
        rsfc_pkg::OP_TBLRD: tbl_step = 1'b1;
        rsfc_pkg::OP_PUSH: st.push = 1'b1;
        rsfc_pkg::OP_POP: st.pop = 1'b1;
        default: redirect = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Program counter: step in phase one, redirect in phase four
  always_ff @(posedge MCLK)
  begin
    if (core_rst)
      pc <= 21'h000000;
    else if (redirect)
      pc <= {target[20:1], 1'b0};
    else if (PHASE[0])
      pc <= pc + rsfc_pkg::PC_STEP;
  end

  // Fetch stage: address out in phase one, word latched in phase four
  always_ff @(posedge MCLK)
  begin
    if (core_rst)
    begin
      PMEM_ADDR <= 21'h000000;
      fetch_buf <= 16'h0000;
      fetch_ok <= 1'b0;
      fetch_next <= 21'h000000;
    end
    else if (PHASE[0])
      PMEM_ADDR <= pc;
    else if (PHASE[3])
    begin
      fetch_buf <= PMEM_RDATA;
      fetch_ok <= !redirect;
      fetch_next <= PMEM_ADDR + rsfc_pkg::PC_STEP;
    end
  end

  // Execute stage: word enters the instruction latch in phase one
  always_ff @(posedge MCLK)
  begin
    if (core_rst)
    begin
      instr <= 16'h0000;
      instr_ok <= 1'b0;
      exec_pc <= 21'h000000;
      operand <= 8'h00;
    end
    else if (PHASE[0])
    begin
      instr <= fetch_buf;
      instr_ok <= fetch_ok;
      exec_pc <= fetch_next;
    end
    else if (PHASE[1])
      operand <= work;
  end

  // Data memory strobes line up with phases two and four
  always_ff @(posedge MCLK)
  begin
    if (core_rst)
    begin
      OPERAND_RD <= 1'b0;
      DEST_WR <= 1'b0;
    end
    else
    begin
      OPERAND_RD <= PHASE[0] & fetch_ok;
      DEST_WR <= PHASE[2] & instr_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Working, status and bank registers with the one-level shadow
  always_ff @(posedge MCLK)
  begin
    if (core_rst)
    begin
      work <= 8'h00;
      status <= 8'h00;
      bank <= 4'h0;
    end
    else if (load_sh)
    begin
      work <= sh_work;
      status <= sh_status;
      bank <= sh_bank;
    end
    else
    begin
      if (set_work)
        work <= work_val;
      else if (hit(rsfc_pkg::OFS_WORK))
        work <= AVS_WRITEDATA[7:0];
      if (hit(rsfc_pkg::OFS_STAT))
        status <= AVS_WRITEDATA[7:0];
      if (hit(rsfc_pkg::OFS_BANK))
        bank <= AVS_WRITEDATA[3:0];
    end
  end

  // Shadow has no bus access; any save overwrites it
  always_ff @(posedge MCLK)
  begin
    if (core_rst)
    begin
      sh_work <= 8'h00;
      sh_status <= 8'h00;
      sh_bank <= 4'h0;
    end
    else if (save_sh)
    begin
      sh_work <= work;
      sh_status <= status;
      sh_bank <= bank;
    end
  end

  // Interrupt service tracking; an OP_RETI return ends the highest level
  always_ff @(posedge MCLK)
  begin
    if (core_rst)
    begin
      in_high <= 1'b0;
      in_low <= 1'b0;
    end
    else if (irq_take)
    begin
      if (IRQ_HIGH & !in_high)
        in_high <= 1'b1;
      else
        in_low <= 1'b1;
    end
    else if (reti)
    begin
      if (in_high)
        in_high <= 1'b0;
      else
        in_low <= 1'b0;
    end
  end

  // Latches, table pointer and table data
  always_ff @(posedge MCLK)
  begin
    if (core_rst)
    begin
      hi_latch <= 8'h00;
      up_latch <= 5'h00;
      TBL_ADDR <= 21'h000000;
      tdata <= 8'h00;
    end
    else
    begin
      if (hit(rsfc_pkg::OFS_LATCH))
      begin
        hi_latch <= AVS_WRITEDATA[7:0];
        up_latch <= AVS_WRITEDATA[12:8];
      end
      if (tbl_step)
      begin
        tdata <= TBL_RDATA;
        TBL_ADDR <= TBL_ADDR + 21'h000001;
      end
      else if (hit(rsfc_pkg::OFS_TPTR))
        TBL_ADDR <= AVS_WRITEDATA[20:0];
    end
  end

  // Configuration survives every reset except power-on
  always_ff @(posedge MCLK)
  begin
    if (!POR_N)
      ctrl <= rsfc_pkg::CTRL_RST;
    else if (hit(rsfc_pkg::OFS_CTRL))
      ctrl <= AVS_WRITEDATA[1:0];
  end

  // Stack fault reset lands on the same edge as the flag sets
  always_ff @(posedge MCLK)
  begin
    if (bus_rst)
      DEV_RESET <= 1'b0;
    else
      DEV_RESET <= st.fault & ctrl[rsfc_pkg::CTRL_FRE_BIT];
  end

  ////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait state; read data is captured as waitrequest falls, writes land one edge later
  always_ff @(posedge MCLK)
  begin
    if (bus_rst)
      AVS_WAITREQUEST <= 1'b1;
    else
      AVS_WAITREQUEST <= !((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST);
  end

  always_ff @(posedge MCLK)
  begin
    if (bus_rst)
      AVS_READDATA <= 32'h00000000;
    else if (AVS_READ & AVS_WAITREQUEST)
    begin
      case (AVS_ADDRESS)
        rsfc_pkg::OFS_SP:
          AVS_READDATA <= {24'h000000, st.full, st.unf, 1'b0, st.sp};
        rsfc_pkg::OFS_CTRL: AVS_READDATA <= {30'h00000000, ctrl};
        rsfc_pkg::OFS_PC: AVS_READDATA <= {11'h000, pc};
        rsfc_pkg::OFS_WORK: AVS_READDATA <= {24'h000000, work};
        rsfc_pkg::OFS_STAT: AVS_READDATA <= {24'h000000, status};
        rsfc_pkg::OFS_BANK: AVS_READDATA <= {28'h0000000, bank};
        rsfc_pkg::OFS_LATCH:
          AVS_READDATA <= {19'h00000, up_latch, hi_latch};
        rsfc_pkg::OFS_TPTR: AVS_READDATA <= {11'h000, TBL_ADDR};
        rsfc_pkg::OFS_TDATA: AVS_READDATA <= {24'h000000, tdata};
        default: AVS_READDATA <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  pc_step_a: assert property (@(posedge MCLK) disable iff (core_rst)
    PHASE[0] |=> pc == $past(pc) + 21'h000002)
    else $error("pc did not step by two");
  pc_even_a: assert property (@(posedge MCLK) disable iff (core_rst)
    pc[0] == 1'b0)
    else $error("pc bit zero set");
  flush_a: assert property (@(posedge MCLK) disable iff (core_rst)
    redirect |=> !fetch_ok ##1 !instr_ok)
    else $error("stale word not flushed");
  abs_jump_a: assert property (@(posedge MCLK) disable iff (core_rst)
    exec && op == rsfc_pkg::OP_GOTO |=> pc[11:1] == $past(instr[10:0]))
    else $error("absolute target wrong");
  fault_rst_a: assert property (@(posedge MCLK) disable iff (bus_rst)
    st.fault && ctrl[0] |-> ##1 (DEV_RESET && (st.full || st.unf)))
    else $error("fault reset missing");
  no_fault_rst_a: assert property (@(posedge MCLK) disable iff (bus_rst)
    st.fault && !ctrl[0] |=> !DEV_RESET)
    else $error("reset while fault reset off");
  shadow_save_a: assert property (@(posedge MCLK) disable iff (core_rst)
    irq_take |=> sh_work == $past(work) && sh_bank == $past(bank))
    else $error("shadow not saved on vector");
  shadow_load_a: assert property (@(posedge MCLK) disable iff (core_rst)
    exec && op == rsfc_pkg::OP_RETI && fast
    |=> work == $past(sh_work) && status == $past(sh_status))
    else $error("shadow not restored");
  tbl_move_a: assert property (@(posedge MCLK) disable iff (core_rst)
    tbl_step |=> tdata == $past(TBL_RDATA)
    && TBL_ADDR == $past(TBL_ADDR) + 21'h000001)
    else $error("table transfer wrong");
endmodule : rsfc_core

// *** core/rsfc_pkg.sv ***
// Shared constants and types for the return stack and fetch control
package rsfc_pkg;
  localparam int PC_W = 21;
  localparam int DEPTH = 31;
  localparam int SP_W = 5;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [20:0] VEC_HIGH = 21'h000008;
  localparam logic [20:0] VEC_LOW = 21'h000018;
  localparam logic [7:0] OFS_SP = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_PC = 8'h08;
  localparam logic [7:0] OFS_WORK = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_BANK = 8'h14;
  localparam logic [7:0] OFS_LATCH = 8'h18;
  localparam logic [7:0] OFS_TPTR = 8'h1C;
  localparam logic [7:0] OFS_TDATA = 8'h20;
  localparam logic [7:0] SP_RST = 8'h00;
  localparam int FULL_BIT = 7;
  localparam int UNF_BIT = 6;
  localparam int CTRL_FRE_BIT = 0;
  localparam int CTRL_IRQ_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam int FAST_BIT = 11;
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_CALL = 4'h1,
    OP_GOTO = 4'h2,
    OP_BRA = 4'h3,
    OP_RET = 4'h4,
    OP_RETI = 4'h5,
    OP_RETLIT = 4'h6,
    OP_ADDPC = 4'h7,
    OP_MOVLIT = 4'h8,
    OP_TBLRD = 4'h9,
    OP_PUSH = 4'hA,
    OP_POP = 4'hB
  } rsfc_op_t;
  typedef enum logic [1:0] {
    PH_ONE = 2'b00,
    PH_TWO = 2'b01,
    PH_THREE = 2'b10,
    PH_FOUR = 2'b11
  } rsfc_phase_t;
endpackage : rsfc_pkg

// *** core/rsfc_stack_if.sv ***
// Signals between the core and its return address stack
`timescale 1ns/1ns
interface rsfc_stack_if;
  logic push;
  logic pop;
  logic [20:0] push_data;
  logic [20:0] top;
  logic sp_wr;
  logic [4:0] sp_wdata;
  logic clr_full;
  logic clr_unf;
  logic [4:0] sp;
  logic full;
  logic unf;
  logic fault;
  modport core (output push, pop, push_data, sp_wr, sp_wdata, clr_full,
    clr_unf, input top, sp, full, unf, fault);
  modport stack (input push, pop, push_data, sp_wr, sp_wdata, clr_full,
    clr_unf, output top, sp, full, unf, fault);
endinterface : rsfc_stack_if

// *** core/rsfc_phase.sv ***
// Four-phase instruction cycle generator
`timescale 1ns/1ns
module rsfc_phase (
  input wire logic clk,
  input wire logic rst_n,
  output logic [3:0] phase
);
  rsfc_pkg::rsfc_phase_t state;
  rsfc_pkg::rsfc_phase_t next_state;

  always_comb
  begin
    case (state)
      rsfc_pkg::PH_ONE: next_state = rsfc_pkg::PH_TWO;
      rsfc_pkg::PH_TWO: next_state = rsfc_pkg::PH_THREE;
      rsfc_pkg::PH_THREE: next_state = rsfc_pkg::PH_FOUR;
      default: next_state = rsfc_pkg::PH_ONE;
    endcase
  end

  // One-hot enables, exactly one phase per clock
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state <= rsfc_pkg::PH_ONE;
      phase <= 4'h1;
    end
    else
    begin
      state <= next_state;
      phase <= 4'(4'h1 << next_state);
    end
  end

  phase_seq_a: assert property (@(posedge clk) disable iff (!rst_n)
    phase[0] |=> phase[1] ##1 phase[2] ##1 phase[3] ##1 phase[0])
    else $error("phase order broken");
endmodule : rsfc_phase

// *** core/rsfc_stack.sv ***
// Return address stack with depth pointer and sticky fault flags
`timescale 1ns/1ns
module rsfc_stack #(
  parameter int DEPTH = rsfc_pkg::DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic por_n,
  rsfc_stack_if.stack st
);
  logic [20:0] mem [1:DEPTH];
  logic empty;
  logic at_top;
  logic near_top;

  assign empty = (st.sp == 5'h00);
  assign at_top = (st.sp >= 5'(DEPTH));
  assign near_top = (st.sp >= 5'(DEPTH - 1));
  // Empty stack returns zero to the program counter
  assign st.top = empty ? 21'h000000 : mem[st.sp];
  assign st.fault = (st.push & near_top) | (st.pop & empty);

  ////////////////////////////////////////////////////////////////////////
  // Pre-increment on push, post-decrement on pop
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st.sp <= rsfc_pkg::SP_RST[4:0];
    else if (st.push & !at_top)
      st.sp <= st.sp + 5'h01;
    else if (st.pop & !empty)
      st.sp <= st.sp - 5'h01;
    else if (st.sp_wr & !st.push & !st.pop)
      st.sp <= st.sp_wdata;
  end

  // Pushes past the last entry leave it untouched
  always_ff @(posedge clk)
  begin
    if (st.push & !at_top)
      mem[5'(st.sp + 5'h01)] <= st.push_data;
  end

  // Flags fall only on software clear or power-on; set wins
  always_ff @(posedge clk)
  begin
    if (!por_n)
    begin
      st.full <= 1'b0;
      st.unf <= 1'b0;
    end
    else
    begin
      st.full <= (st.full & !st.clr_full) | (st.push & near_top);
      st.unf <= (st.unf & !st.clr_unf) | (st.pop & empty);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  full_set_a: assert property (@(posedge clk) disable iff (!rst_n || !por_n)
    st.push && st.sp == 5'(DEPTH - 1) |=> st.full && st.sp == 5'(DEPTH))
    else $error("full flag or pointer wrong");
  sp_hold_a: assert property (@(posedge clk) disable iff (!rst_n || !por_n)
    st.push && at_top |=> st.sp == $past(st.sp) && st.full)
    else $error("pointer moved past top");
  unf_set_a: assert property (@(posedge clk) disable iff (!rst_n || !por_n)
    st.pop && empty |-> st.top == 21'h000000 ##1 st.unf && st.sp == 5'h00)
    else $error("underflow handling wrong");
  flag_keep_a: assert property (@(posedge clk) disable iff (!por_n)
    $fell(st.full) |-> $past(st.clr_full))
    else $error("full flag dropped without clear");
endmodule : rsfc_stack

// *** verif/rsfc_pmem_model.sv ***
// Program memory and table byte source facing the core
`timescale 1ns/1ns
module rsfc_pmem_model (
  input wire logic [20:0] pmem_addr,
  output logic [15:0] pmem_rdata,
  input wire logic [20:0] tbl_addr,
  output logic [7:0] tbl_rdata
);
  logic [15:0] mem [0:63];
  // Whole words at even byte addresses; outside the image reads nop
  assign pmem_rdata = (pmem_addr[20:7] == 14'h0000) ? mem[pmem_addr[6:1]]
    : 16'h0000;
  assign tbl_rdata = tbl_addr[7:0] ^ 8'h5A;
endmodule : rsfc_pmem_model

// *** verif/rsfc_tb_top.sv ***
// Self-checking bench for the return stack and fetch control core
`timescale 1ns/1ns
module rsfc_tb_top;
  logic mclk, rst_n, por_n, avs_read, avs_write, avs_waitrequest;
  logic [7:0] avs_address, tbl_rdata;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [20:0] pmem_addr, tbl_addr;
  logic [15:0] pmem_rdata;
  logic irq_high, irq_low, operand_rd, dest_wr, dev_reset, live, dev_d;
  logic [3:0] phase, prev_phase;
  int failures, comparisons, cycles, dev_count;
  rsfc_core i_dut (
    .MCLK(mclk), .RST_N(rst_n), .POR_N(por_n),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
    .PMEM_ADDR(pmem_addr), .PMEM_RDATA(pmem_rdata),
    .TBL_ADDR(tbl_addr), .TBL_RDATA(tbl_rdata),
    .IRQ_HIGH(irq_high), .IRQ_LOW(irq_low), .PHASE(phase),
    .OPERAND_RD(operand_rd), .DEST_WR(dest_wr), .DEV_RESET(dev_reset)
  );
  rsfc_pmem_model i_mem (
    .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata),
    .tbl_addr(tbl_addr), .tbl_rdata(tbl_rdata)
  );
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp,
    input string msg);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got,
        exp);
    end
  endtask : check_val
  task automatic check_bit(input logic got, input logic exp,
    input string msg);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check_bit
  // Request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    check_bit(avs_waitrequest, 1'b0, "bus answer");
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, q);
    check_val(q & m, exp, "register read");
  endtask : rd_chk
  task automatic run(input int n);
    repeat (n) @(posedge mclk);
  endtask : run
  task automatic pulse(input logic por);
    @(posedge mclk);
    rst_n <= 1'b0;
    por_n <= ~por;
    run(2);
    rst_n <= 1'b1;
    por_n <= 1'b1;
  endtask : pulse
  task automatic prog(input logic [15:0] w[$]);
    for (int k = 0; k < 64; k++)
      i_mem.mem[k] = (k < w.size()) ? w[k] : 16'h0000;
  endtask : prog
  //////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd_chk(rsfc_pkg::OFS_SP, 32'hFF, 32'h00);
    rd_chk(rsfc_pkg::OFS_CTRL, 32'hFF, 32'h01);
    rd_chk(8'hFC, 32'hFFFFFFFF, 32'h0);
    wr(rsfc_pkg::OFS_SP, 32'hFF);
    rd_chk(rsfc_pkg::OFS_SP, 32'hFF, 32'h1F);
    wr(rsfc_pkg::OFS_SP, 32'h00);
  endtask : t_regs
  task automatic t_underflow;
    wr(rsfc_pkg::OFS_CTRL, 32'h0);
    prog('{16'h4000});
    pulse(1'b0);
    run(40);
    rd_chk(rsfc_pkg::OFS_SP, 32'hFF, 32'h40);
    check_val(32'(dev_count), 32'h0, "no reset");
    prog('{16'h2000});
    pulse(1'b0);
    rd_chk(rsfc_pkg::OFS_SP, 32'hFF, 32'h40);
    wr(rsfc_pkg::OFS_SP, 32'h00);
    rd_chk(rsfc_pkg::OFS_SP, 32'hFF, 32'h00);
  endtask : t_underflow
  task automatic t_full_and_fault;
    prog('{16'h1000});
    pulse(1'b0);
    run(400);
    rd_chk(rsfc_pkg::OFS_SP, 32'hFF, 32'h9F);
    check_val(32'(dev_count), 32'h0, "no reset");
    pulse(1'b1);
    rd_chk(rsfc_pkg::OFS_SP, 32'hE0, 32'h00);
    rd_chk(rsfc_pkg::OFS_CTRL, 32'hFF, 32'h01);
    run(400);
    check_bit(dev_count != 0, 1'b1, "fault reset");
    rd_chk(rsfc_pkg::OFS_SP, 32'hE0, 32'h80);
    prog('{16'h2000});
    pulse(1'b1);
    wr(rsfc_pkg::OFS_CTRL, 32'h0);
  endtask : t_full_and_fault
  task automatic t_prog_flow;
    // Fast call saves working, callee changes it, fast return restores
    prog('{16'h8055, 16'h1803, 16'h2002, 16'h80AA, 16'h4800});
    pulse(1'b0);
    run(100);
    rd_chk(rsfc_pkg::OFS_WORK, 32'hFF, 32'h55);
    // Even offset of four skips two entries
    prog('{16'h8004, 16'h7000, 16'h8044, 16'h2003, 16'h8033, 16'h2005});
    pulse(1'b0);
    run(100);
    rd_chk(rsfc_pkg::OFS_WORK, 32'hFF, 32'h33);
  endtask : t_prog_flow
  task automatic t_branch;
    // Call, literal return, then a one-word forward branch over a literal
    prog('{16'h1004, 16'h3001, 16'h8099, 16'h2003, 16'h6042});
    pulse(1'b0);
    run(80);
    rd_chk(rsfc_pkg::OFS_WORK, 32'hFF, 32'h42);
    rd_chk(rsfc_pkg::OFS_SP, 32'hFF, 32'h00);
  endtask : t_branch
  task automatic t_irq;
    // Low service loops; a high request overwrites its shadow copy
    prog('{16'h8011, 16'h2001, 16'h0000, 16'h0000, 16'h8077, 16'h5800,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h8066, 16'h200D});
    pulse(1'b0);
    wr(rsfc_pkg::OFS_CTRL, 32'h2);
    run(20);
    irq_low <= 1'b1;
    run(24);
    irq_low <= 1'b0;
    rd_chk(rsfc_pkg::OFS_WORK, 32'hFF, 32'h66);
    rd_chk(rsfc_pkg::OFS_SP, 32'hFF, 32'h01);
    irq_high <= 1'b1;
    run(10);
    irq_high <= 1'b0;
    run(40);
    rd_chk(rsfc_pkg::OFS_WORK, 32'hFF, 32'h66);
    rd_chk(rsfc_pkg::OFS_SP, 32'hFF, 32'h01);
    wr(rsfc_pkg::OFS_CTRL, 32'h0);
  endtask : t_irq
  task automatic t_table;
    logic [15:0] w[$];
    for (int k = 0; k < 16; k++)
      w.push_back(16'h0000);
    w.push_back(16'h9000);
    w.push_back(16'h2011);
    prog(w);
    pulse(1'b0);
    wr(rsfc_pkg::OFS_TPTR, 32'h123);
    run(120);
    rd_chk(rsfc_pkg::OFS_TDATA, 32'hFF, {24'h0, 8'h23 ^ 8'h5A});
    rd_chk(rsfc_pkg::OFS_TPTR, 32'h1FFFFF, 32'h124);
  endtask : t_table
  //////////////////////////////////////////////////////////////////////////
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      $display("CHECK FAILED at %0t: timeout", $time);
      report_and_stop();
    end
  end
  always @(posedge mclk)
  begin
    if (dev_reset === 1'b1)
      dev_count++;
    if (live === 1'b1)
    begin
      check_bit(phase === {prev_phase[2:0], prev_phase[3]}, 1'b1,
        "phase order");
      check_bit(pmem_addr[0], 1'b0, "odd fetch");
      if (operand_rd === 1'b1)
        check_bit(phase[1], 1'b1, "read phase");
      if (dest_wr === 1'b1)
        check_bit(phase[3], 1'b1, "write phase");
    end
    prev_phase = phase;
    live = rst_n & por_n & ~dev_reset & ~dev_d;
    dev_d = dev_reset;
  end
  initial
  begin
    {rst_n, por_n, avs_read, avs_write, irq_high, irq_low} = 6'h00;
    {live, dev_d, prev_phase} = 6'h00;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    failures = 0;
    comparisons = 0;
    cycles = 0;
    dev_count = 0;
    prog('{16'h0000});
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    t_regs();
    t_underflow();
    t_full_and_fault();
    t_prog_flow();
    t_branch();
    t_irq();
    t_table();
    report_and_stop();
  end
endmodule : rsfc_tb_top
